// ===== logic/cmsd_decoder.sv
// memory space decoder: program flash, internal ram, stack, local sfrs
// assumes the execution unit issues one access per cycle; peripherals
// decode acc_addr themselves and return sfr_rdata in the same cycle
`timescale 1ns/100ps
`default_nettype none
module cmsd_decoder #(
  parameter int FLASH_BYTES = cmsd_pkg::FLASH_16K
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 acc_valid,
  input  wire cmsd_pkg::cmsd_kind_t acc_kind,
  input  wire logic                 acc_write,
  input  wire logic [15:0]          acc_addr,
  input  wire logic [7:0]           acc_wdata,
  input  wire logic                 acc_bit_wval,
  input  wire logic [7:0]           sfr_rdata,
  output logic                      rd_valid_reg,
  output logic [7:0]                rd_data_reg,
  output logic                      rd_bit_reg,
  output logic                      sfr_we_reg,
  output logic [7:0]                sfr_waddr_reg,
  output logic [7:0]                sfr_wdata_reg,
  output logic [7:0]                stack_pointer_reg,
  output logic [7:0]                program_status_word_reg,
  output logic [7:0]                program_store_control_reg
);
  localparam logic [15:0] FLASH_TOP = 16'(FLASH_BYTES - 1);

  logic [7:0] ram [0:cmsd_pkg::RAM_BYTES-1];
  logic [7:0] flash [0:FLASH_BYTES-1];

  // reserved holes of the special register space
  function automatic logic sfr_occupied(input logic [7:0] a);
    case (a)
      8'h84, 8'h85, 8'h86, 8'h96, 8'h97, 8'hab, 8'hac, 8'had, 8'hae, 8'haf,
      8'hb4, 8'hb9, 8'hbf, 8'hc7, 8'hc9, 8'hce, 8'hcf, 8'hd2, 8'hd3, 8'hd7,
      8'hdf, 8'he3, 8'he5, 8'hf5: sfr_occupied = 1'b0;
      default: sfr_occupied = a[7];
    endcase
  endfunction

  wire logic [1:0] bank       = program_status_word_reg[cmsd_pkg::PSW_BANK_LSB +: 2];
  wire logic [7:0] ri_index   = {3'h0, bank, 2'h0, acc_addr[0]};
  wire logic [7:0] ind_addr   = ram[ri_index];
  wire logic [7:0] bit_byte   = acc_addr[7] ? {acc_addr[7:3], 3'h0}
                                            : {cmsd_pkg::BIT_AREA_HI, acc_addr[6:3]};
  wire logic [2:0] bit_pos    = acc_addr[2:0];
  wire logic       is_bit     = acc_kind == cmsd_pkg::KIND_BIT;
  wire logic       is_direct  = acc_kind == cmsd_pkg::KIND_DIRECT;
  wire logic       is_ind     = acc_kind == cmsd_pkg::KIND_INDIRECT;
  wire logic       is_push    = acc_kind == cmsd_pkg::KIND_PUSH;
  wire logic       is_pop     = acc_kind == cmsd_pkg::KIND_POP;
  wire logic       is_code    = acc_kind == cmsd_pkg::KIND_CODE_READ;
  wire logic       is_xmove   = acc_kind == cmsd_pkg::KIND_EXT_MOVE;
  wire logic [7:0] sp_inc     = stack_pointer_reg + 8'h01;
  wire logic [7:0] sp_dec     = stack_pointer_reg - 8'h01;

  // data space target byte address
  wire logic [7:0] tgt = is_bit  ? bit_byte :
                         is_ind  ? ind_addr :
                         is_push ? sp_inc :
                         is_pop  ? stack_pointer_reg :
                         acc_addr[7:0];
  wire logic to_sfr   = (is_direct || is_bit) && tgt[7];
  wire logic data_acc = is_direct || is_bit || is_ind;
  wire logic tgt_sp   = to_sfr && tgt == cmsd_pkg::SP_ADDR;
  wire logic tgt_psw  = to_sfr && tgt == cmsd_pkg::PSW_ADDR;
  wire logic tgt_psc  = to_sfr && tgt == cmsd_pkg::PROGRAM_STORE_CONTROL_ADDR;
  wire logic tgt_ext  = to_sfr && sfr_occupied(tgt) && !tgt_sp && !tgt_psw && !tgt_psc;

  wire logic [7:0] sfr_val = tgt_sp  ? stack_pointer_reg :
                             tgt_psw ? program_status_word_reg :
                             tgt_psc ? program_store_control_reg :
                             tgt_ext ? sfr_rdata : 8'h00;
  wire logic [7:0] byte_rd = to_sfr ? sfr_val : ram[tgt];

  // program space: flash up to top; beyond top, and the reserved tail of the 16K part only, read zero
  wire logic code_rsvd = (FLASH_BYTES == cmsd_pkg::FLASH_16K) &&
                         (acc_addr > cmsd_pkg::CODE_RSVD_ABOVE);
  wire logic code_ok   = acc_addr <= FLASH_TOP && !code_rsvd;
  wire logic [7:0] code_rd = code_ok ? flash[acc_addr[$clog2(FLASH_BYTES)-1:0]] : 8'h00;

  wire logic [7:0] bit_mask;
  // one-hot lane select for bit writes
  generate
    for (genvar gi = 0; gi < 8; gi++)
    begin : g_lane
      assign bit_mask[gi] = bit_pos == 3'(gi);
    end
  endgenerate
  wire logic [7:0] merged   = (byte_rd & ~bit_mask) | (acc_bit_wval ? bit_mask : 8'h00);
  wire logic [7:0] wbyte    = is_bit ? merged : acc_wdata;
  wire logic       wr       = acc_valid && acc_write;
  wire logic       rd_req   = acc_valid && !is_push && (!acc_write || is_code || is_pop);

  wire logic ram_we   = (wr && data_acc && !to_sfr) || (acc_valid && is_push);
  wire logic flash_we = wr && is_xmove && code_ok &&
                        program_store_control_reg[cmsd_pkg::PROGRAM_STORE_CONTROL_WREN_BIT];
  wire logic sp_we    = wr && tgt_sp;
  wire logic ext_we   = wr && tgt_ext;

  wire logic [7:0] rd_next = is_code ? code_rd :
                             (is_xmove ? 8'h00 : byte_rd);
  wire logic [7:0] sp_next = (acc_valid && is_push) ? sp_inc :
                             (acc_valid && is_pop)  ? sp_dec :
                             sp_we ? wbyte : stack_pointer_reg;

  always_ff @(posedge ref_clk)
  begin
    if (ram_we)
      ram[tgt] <= is_push ? acc_wdata : wbyte;
    if (flash_we)
      flash[acc_addr[$clog2(FLASH_BYTES)-1:0]] <= acc_wdata;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stack_pointer_reg         <= cmsd_pkg::SP_RESET;
      program_status_word_reg   <= cmsd_pkg::PSW_RESET;
      program_store_control_reg <= cmsd_pkg::PROGRAM_STORE_CONTROL_RESET;
    end
    else
    begin
      stack_pointer_reg <= sp_next;
      if (wr && tgt_psw)
        program_status_word_reg <= wbyte;
      if (wr && tgt_psc)
        program_store_control_reg <= wbyte;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_valid_reg  <= 1'b0;
      rd_data_reg   <= 8'h00;
      rd_bit_reg    <= 1'b0;
      sfr_we_reg    <= 1'b0;
      sfr_waddr_reg <= 8'h00;
      sfr_wdata_reg <= 8'h00;
    end
    else
    begin
      rd_valid_reg  <= rd_req;
      rd_data_reg   <= rd_next;
      rd_bit_reg    <= byte_rd[bit_pos];
      sfr_we_reg    <= ext_we;
      sfr_waddr_reg <= tgt;
      sfr_wdata_reg <= wbyte;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_sp_reset;
    $rose(rst_n) |-> stack_pointer_reg == cmsd_pkg::SP_RESET;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("stack pointer not 0x07 after reset");

  property p_push;
    acc_valid && is_push |=> stack_pointer_reg == $past(stack_pointer_reg) + 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("push did not advance stack pointer");

  property p_pop;
    acc_valid && is_pop |=> stack_pointer_reg == $past(stack_pointer_reg) - 8'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not retreat stack pointer");

  property p_code_rsvd;
    acc_valid && is_code && code_rsvd |=> rd_valid_reg && rd_data_reg == 8'h00;
  endproperty
  a_code_rsvd: assert property (p_code_rsvd) else $error("reserved program address read nonzero");

  property p_flash_lock;
    flash_we |-> program_store_control_reg[0] && is_xmove;
  endproperty
  a_flash_lock: assert property (p_flash_lock) else $error("program write without enable");

  property p_sfr_bit_align;
    acc_valid && is_bit && acc_write && acc_addr[7] |=> !sfr_we_reg || sfr_waddr_reg[2:0] == 3'h0;
  endproperty
  a_sfr_bit_align: assert property (p_sfr_bit_align) else $error("bit write to non bit sfr");

  property p_bit_area;
    acc_valid && is_bit && !acc_addr[7] |-> tgt == 8'h20 + {4'h0, acc_addr[6:3]};
  endproperty
  a_bit_area: assert property (p_bit_area) else $error("bit address mapped wrong");

  property p_direct_sfr;
    acc_valid && is_direct && acc_addr[7] |-> to_sfr && !ram_we;
  endproperty
  a_direct_sfr: assert property (p_direct_sfr) else $error("direct high access hit ram");

  property p_unocc;
    acc_valid && !acc_write && is_direct && acc_addr[7] && !sfr_occupied(acc_addr[7:0])
      |=> rd_data_reg == 8'h00 && !sfr_we_reg;
  endproperty
  a_unocc: assert property (p_unocc) else $error("unoccupied sfr read nonzero");

  property p_ind_upper;
    acc_valid && is_ind && acc_write |-> ram_we && !to_sfr;
  endproperty
  a_ind_upper: assert property (p_ind_upper) else $error("indirect write missed ram");

  property p_direct_low;
    acc_valid && is_direct && !acc_addr[7] |-> !to_sfr && tgt == acc_addr[7:0];
  endproperty
  a_direct_low: assert property (p_direct_low) else $error("direct low access left ram");

  property p_ind_ram;
    acc_valid && is_ind |-> !to_sfr && !ext_we;
  endproperty
  a_ind_ram: assert property (p_ind_ram) else $error("indirect access reached sfr space");

  property p_ind_read;
    acc_valid && is_ind && !acc_write |=> rd_valid_reg;
  endproperty
  a_ind_read: assert property (p_ind_read) else $error("indirect read not answered");

  property p_ri_bank;
    acc_valid && is_ind |-> ri_index[2:1] == 2'h0 &&
      ri_index[7:3] == {3'h0, program_status_word_reg[cmsd_pkg::PSW_BANK_LSB +: 2]};
  endproperty
  a_ri_bank: assert property (p_ri_bank) else $error("index register outside active bank");

  property p_bit_sfr;
    acc_valid && is_bit && acc_addr[7] |-> to_sfr && tgt[2:0] == 3'h0;
  endproperty
  a_bit_sfr: assert property (p_bit_sfr) else $error("sfr bit access off column zero or eight");

  property p_bit_merge;
    acc_valid && is_bit |-> wbyte[bit_pos] == acc_bit_wval && (wbyte & ~bit_mask) == (byte_rd & ~bit_mask);
  endproperty
  a_bit_merge: assert property (p_bit_merge) else $error("bit write disturbed other bits");

  property p_bit_read;
    acc_valid && is_bit && !acc_write |=> rd_valid_reg && rd_bit_reg == rd_data_reg[$past(bit_pos)];
  endproperty
  a_bit_read: assert property (p_bit_read) else $error("bit read returned wrong lane");

  property p_push_slot;
    acc_valid && is_push |-> ram_we && tgt == sp_inc;
  endproperty
  a_push_slot: assert property (p_push_slot) else $error("push not written above pointer");

  property p_pop_slot;
    acc_valid && is_pop |-> !ram_we && tgt == stack_pointer_reg;
  endproperty
  a_pop_slot: assert property (p_pop_slot) else $error("pop not read at pointer");

  property p_sp_idle;
    !acc_valid |=> $stable(stack_pointer_reg);
  endproperty
  a_sp_idle: assert property (p_sp_idle) else $error("stack pointer moved while idle");

  property p_sp_load;
    acc_valid && acc_write && is_direct && acc_addr[7:0] == cmsd_pkg::SP_ADDR
      |=> stack_pointer_reg == $past(acc_wdata);
  endproperty
  a_sp_load: assert property (p_sp_load) else $error("stack pointer write lost");

  property p_psw_load;
    acc_valid && acc_write && is_direct && acc_addr[7:0] == cmsd_pkg::PSW_ADDR
      |=> program_status_word_reg == $past(acc_wdata);
  endproperty
  a_psw_load: assert property (p_psw_load) else $error("status word write lost");

  property p_psc_load;
    acc_valid && acc_write && is_direct && acc_addr[7:0] == cmsd_pkg::PROGRAM_STORE_CONTROL_ADDR
      |=> program_store_control_reg == $past(acc_wdata);
  endproperty
  a_psc_load: assert property (p_psc_load) else $error("store control write lost");

  property p_code_kinds;
    acc_valid && (is_code || is_xmove) |-> !ram_we && !ext_we && !sp_we;
  endproperty
  a_code_kinds: assert property (p_code_kinds) else $error("program access touched data space");

  property p_code_read;
    acc_valid && is_code |=> rd_valid_reg;
  endproperty
  a_code_read: assert property (p_code_read) else $error("program read not answered");

  property p_xmove_rd;
    acc_valid && is_xmove && !acc_write |=> rd_valid_reg && rd_data_reg == 8'h00;
  endproperty
  a_xmove_rd: assert property (p_xmove_rd) else $error("external move read nonzero");

  property p_idle_quiet;
    !acc_valid |=> !rd_valid_reg && !sfr_we_reg;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("answer without request");

  property p_code_top;
    acc_valid && is_code && acc_addr > FLASH_TOP |=> rd_data_reg == 8'h00;
  endproperty
  a_code_top: assert property (p_code_top) else $error("read beyond flash nonzero");

  property p_flash_range;
    flash_we |-> acc_addr <= FLASH_TOP && !code_rsvd;
  endproperty
  a_flash_range: assert property (p_flash_range) else $error("program write outside flash");

  property p_sfr_strobe;
    sfr_we_reg |-> sfr_waddr_reg[7] && sfr_occupied(sfr_waddr_reg);
  endproperty
  a_sfr_strobe: assert property (p_sfr_strobe) else $error("strobe to unoccupied sfr");

  property p_local_kept;
    acc_valid && acc_write && (tgt_sp || tgt_psw || tgt_psc) |=> !sfr_we_reg;
  endproperty
  a_local_kept: assert property (p_local_kept) else $error("local register write forwarded");

  property p_unocc_wr;
    acc_valid && acc_write && is_direct && acc_addr[7] && !sfr_occupied(acc_addr[7:0]) |-> !ram_we && !ext_we;
  endproperty
  a_unocc_wr: assert property (p_unocc_wr) else $error("unoccupied sfr write landed");

  c_push_pop: cover property (acc_valid && is_push ##1 acc_valid && is_pop);
  c_flash_wr: cover property (flash_we);
  c_sfr_bit:  cover property (acc_valid && is_bit && acc_write && tgt_ext);
  c_bank3:    cover property (acc_valid && is_ind && bank == 2'h3);
  c_bit_rd:   cover property (acc_valid && is_bit && !acc_write);
endmodule
`default_nettype wire

// ===== logic/cmsd_pkg.sv
// address map constants and access kinds for the memory space decoder
// assumes one synchronous clock domain shared with the execution unit
`default_nettype none
package cmsd_pkg;
  localparam logic [7:0]  SP_ADDR        = 8'h81;
  localparam logic [7:0]  PROGRAM_STORE_CONTROL_ADDR     = 8'h8f;
  localparam logic [7:0]  PSW_ADDR       = 8'hd0;
  localparam logic [7:0]  SP_RESET       = 8'h07;
  localparam logic [7:0]  PSW_RESET      = 8'h00;
  localparam logic [7:0]  PROGRAM_STORE_CONTROL_RESET    = 8'h00;
  localparam int          PSW_BANK_LSB   = 3;
  localparam int          PROGRAM_STORE_CONTROL_WREN_BIT = 0;
  localparam logic [3:0]  BIT_AREA_HI    = 4'h2;
  localparam logic [15:0] CODE_RSVD_ABOVE = 16'h3e00;
  localparam int          FLASH_16K      = 16384;
  localparam int          FLASH_8K       = 8192;
  localparam int          RAM_BYTES      = 256;
  typedef enum logic [2:0] {
    KIND_CODE_READ,
    KIND_DIRECT,
    KIND_INDIRECT,
    KIND_BIT,
    KIND_EXT_MOVE,
    KIND_PUSH,
    KIND_POP
  } cmsd_kind_t;
endpackage
`default_nettype wire

// ===== bench/cmsd_periph_model.sv
// peripheral register stand-in on the decoder's far side
// assumes reads follow acc_addr at once and writes land on the strobe
`timescale 1ns/100ps
`default_nettype none
module cmsd_periph_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] rd_addr,
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);
  logic [7:0] mem [256];
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
  end
  assign rdata = mem[rd_addr];
  always @(posedge ref_clk)
    if (we)
      mem[waddr] <= wdata;
endmodule
`default_nettype wire

// ===== bench/core_memory_space_decoder_tb.sv
// self-checking bench for the memory space decoder
// assumes one access answered one clock later, as the decoder hands over
`timescale 1ns/100ps
`default_nettype none
module core_memory_space_decoder_tb;
  logic                 ref_clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 v = 1'b0;
  cmsd_pkg::cmsd_kind_t k = cmsd_pkg::KIND_DIRECT;
  logic                 w = 1'b0;
  logic [15:0]          a = 16'h0000;
  logic [7:0]           d = 8'h00;
  logic                 b = 1'b0;
  logic [7:0]           sfr_rd;
  logic                 rv, rb, we;
  logic [7:0]           rdat, wa, wd, sp, program_status_word, psc;
  int                   fails = 0;
  int                   comparisons = 0;
  always #4 ref_clk = ~ref_clk;
  cmsd_decoder #(.FLASH_BYTES(cmsd_pkg::FLASH_16K)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .acc_valid(v),
    .acc_kind(k), .acc_write(w), .acc_addr(a), .acc_wdata(d), .acc_bit_wval(b), .sfr_rdata(sfr_rd),
    .rd_valid_reg(rv), .rd_data_reg(rdat), .rd_bit_reg(rb), .sfr_we_reg(we), .sfr_waddr_reg(wa),
    .sfr_wdata_reg(wd), .stack_pointer_reg(sp), .program_status_word_reg(program_status_word), .program_store_control_reg(psc));
  cmsd_periph_model far (.ref_clk(ref_clk), .rd_addr(k == cmsd_pkg::KIND_BIT ? {a[7:3], 3'h0} : a[7:0]),
    .we(we), .waddr(wa), .wdata(wd), .rdata(sfr_rd));
  task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task acc(input cmsd_pkg::cmsd_kind_t kd, input logic wr, input logic [15:0] ad, input logic [7:0] dt, input logic bv);
    @(posedge ref_clk);
    #1 v = 1'b1;
    k = kd;
    w = wr;
    a = ad;
    d = dt;
    b = bv;
    @(posedge ref_clk);
    #1 v = 1'b0;
  endtask
  task wr_d(input logic [7:0] ad, input logic [7:0] dt);
    acc(cmsd_pkg::KIND_DIRECT, 1'b1, {8'h00, ad}, dt, 1'b0);
  endtask
  task rd(input cmsd_pkg::cmsd_kind_t kd, input logic [15:0] ad, input logic [7:0] exp);
    acc(kd, 1'b0, ad, 8'h00, 1'b0);
    chk("rd_valid", {7'h00, rv}, 8'h01);
    chk("rd_data", rdat, exp);
  endtask
  task t_stack;
    chk("sp_reset", sp, 8'h07);
    chk("psw_reset", program_status_word, 8'h00);
    chk("program_store_control_reset", psc, 8'h00);
    acc(cmsd_pkg::KIND_PUSH, 1'b1, 16'h0000, 8'haa, 1'b0);
    chk("sp_push", sp, 8'h08);
    rd(cmsd_pkg::KIND_DIRECT, 16'h0008, 8'haa);
    rd(cmsd_pkg::KIND_POP, 16'h0000, 8'haa);
    chk("sp_pop", sp, 8'h07);
    wr_d(8'h81, 8'hff);
    acc(cmsd_pkg::KIND_PUSH, 1'b1, 16'h0000, 8'h11, 1'b0);
    chk("sp_wrap", sp, 8'h00);
    rd(cmsd_pkg::KIND_DIRECT, 16'h0000, 8'h11);
    $display("test stack done");
  endtask
  task t_space;
    wr_d(8'h30, 8'h66);
    wr_d(8'h00, 8'h30);
    rd(cmsd_pkg::KIND_INDIRECT, 16'h0000, 8'h66);
    wr_d(8'h00, 8'h90);
    acc(cmsd_pkg::KIND_INDIRECT, 1'b1, 16'h0000, 8'h5a, 1'b0);
    rd(cmsd_pkg::KIND_INDIRECT, 16'h0000, 8'h5a);
    rd(cmsd_pkg::KIND_DIRECT, 16'h0090, 8'hca);
    wr_d(8'ha0, 8'h05);
    chk("sfr_we", {7'h00, we}, 8'h01);
    chk("sfr_waddr", wa, 8'ha0);
    chk("sfr_wdata", wd, 8'h05);
    wr_d(8'hd0, 8'h10);
    wr_d(8'h11, 8'h30);
    rd(cmsd_pkg::KIND_INDIRECT, 16'h0001, 8'h66);
    acc(cmsd_pkg::KIND_BIT, 1'b1, 16'h00d3, 8'h00, 1'b1);
    chk("psw_bit", program_status_word, 8'h18);
    acc(cmsd_pkg::KIND_BIT, 1'b1, 16'h0081, 8'h00, 1'b0);
    chk("sp_no_bit", sp, 8'h00);
    chk("bit_waddr", wa, 8'h80);
    chk("bit_wdata", wd, 8'hd8);
    $display("test space done");
  endtask
  task t_bits;
    wr_d(8'h22, 8'h00);
    acc(cmsd_pkg::KIND_BIT, 1'b1, 16'h0013, 8'h00, 1'b1);
    rd(cmsd_pkg::KIND_DIRECT, 16'h0022, 8'h08);
    wr_d(8'h2f, 8'h80);
    acc(cmsd_pkg::KIND_BIT, 1'b0, 16'h007f, 8'h00, 1'b0);
    chk("bit_7f", {7'h00, rb}, 8'h01);
    acc(cmsd_pkg::KIND_BIT, 1'b0, 16'h007e, 8'h00, 1'b0);
    chk("bit_7e", {7'h00, rb}, 8'h00);
    rd(cmsd_pkg::KIND_DIRECT, 16'h0084, 8'h00);
    wr_d(8'h84, 8'h33);
    chk("unocc_we", {7'h00, we}, 8'h00);
    $display("test bits done");
  endtask
  task t_prog;
    wr_d(8'h8f, 8'h01);
    acc(cmsd_pkg::KIND_EXT_MOVE, 1'b1, 16'h0040, 8'h3c, 1'b0);
    wr_d(8'h8f, 8'h00);
    acc(cmsd_pkg::KIND_EXT_MOVE, 1'b1, 16'h0040, 8'h11, 1'b0);
    wr_d(8'h40, 8'h77);
    rd(cmsd_pkg::KIND_CODE_READ, 16'h0040, 8'h3c);
    rd(cmsd_pkg::KIND_DIRECT, 16'h0040, 8'h77);
    rd(cmsd_pkg::KIND_CODE_READ, 16'h3f00, 8'h00);
    $display("test prog done");
  endtask
  task t_order;
    @(posedge ref_clk);
    #1 v = 1'b1;
    k = cmsd_pkg::KIND_PUSH;
    w = 1'b1;
    a = 16'h0000;
    d = 8'h5c;
    @(posedge ref_clk);
    #1 k = cmsd_pkg::KIND_POP;
    w = 1'b0;
    @(posedge ref_clk);
    #1 v = 1'b0;
    chk("b2b_valid", {7'h00, rv}, 8'h01);
    chk("b2b_pop", rdat, 8'h5c);
    chk("b2b_sp", sp, 8'h00);
    wr_d(8'h19, 8'h2f);
    rd(cmsd_pkg::KIND_INDIRECT, 16'h0001, 8'h80);
    rd(cmsd_pkg::KIND_CODE_READ, 16'h4000, 8'h00);
    rd(cmsd_pkg::KIND_EXT_MOVE, 16'h0040, 8'h00);
    $display("test order done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_stack();
    t_space();
    t_bits();
    t_prog();
    t_order();
    conclude();
  end
endmodule
`default_nettype wire
